// ---- hw/secp_top.sv ----
// serial emphasis configuration port: shift register, load strobe capture, fallback
`timescale 1ns/100ps
module secp_top (
  // system clock and reset
  input  wire logic                          REF_CLK_IN,
  input  wire logic                          SYS_RST_IN,
  // serial configuration link from the controller
  input  wire logic                          SERIAL_CLOCK_IN,
  input  wire logic                          SERIAL_DATA_IN,
  input  wire logic                          CONFIG_LOAD_STROBE_IN,
  // cascade toward the next device
  output logic                               CASCADE_DATA_OUT,
  output logic                               CASCADE_CLOCK_OUT,
  // effective settings
  output logic [secp_pkg::EMPH_W-1:0]        EMPHASIS_LEVEL_OUT,
  output logic                               EQUALIZER_ENABLE_OUT,
  // line path switch controls, exactly one high
  output logic                               EQ_ROUTE_OUT,
  output logic                               EQ_BYPASS_OUT
);

  secp_pkg::secp_ctl_state_t ctl_reg;
  secp_pkg::secp_ctl_state_t ctl_next;
  logic                      strobe_rise;

  secp_link_if lnk ();

  secp_shift u_shift (
    .serial_clock_in (SERIAL_CLOCK_IN),
    .link_rst_in     (ctl_reg.link_rst),
    .serial_data_in  (SERIAL_DATA_IN),
    .lnk             (lnk.shifter)
  );

  // rising edge seen after the synchroniser, never on its first stage
  assign strobe_rise = ctl_reg.strobe_sync & ~ctl_reg.strobe_prev;

  always_comb begin
    ctl_next = ctl_reg;
    ctl_next.link_rst = 1'h0;

    // strobe is sampled independently of the serial clock
    ctl_next.strobe_meta = CONFIG_LOAD_STROBE_IN;
    ctl_next.strobe_sync = ctl_reg.strobe_meta;
    ctl_next.strobe_prev = ctl_reg.strobe_sync;

    // the word is static around the strobe edge since shifting has stopped,
    // so a plain two-stage sync of all five bits is coherent at capture
    ctl_next.word_meta = lnk.word;
    ctl_next.word_sync = ctl_reg.word_meta;

    if (!ctl_reg.strobe_sync) begin
      // strobe low or open: fall back regardless of the serial lines
      ctl_next.emph = secp_pkg::EMPH_0DB;
      ctl_next.eq   = secp_pkg::EQ_OFF;
    end else if (strobe_rise) begin
      // word_sync lags the pins as much as strobe_sync does, so this is
      // the contents present just before the strobe went high
      ctl_next.emph = ctl_reg.word_sync[secp_pkg::EMPH_MSB:secp_pkg::EMPH_LSB];
      ctl_next.eq   = ctl_reg.word_sync[secp_pkg::EQ_BIT];
    end
    // otherwise strobe stays high and the settings hold

    ctl_next.eq_route     = ctl_next.eq;
    ctl_next.bypass_route = ~ctl_next.eq;
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      ctl_reg <= secp_pkg::CTL_RST;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  assign EMPHASIS_LEVEL_OUT   = ctl_reg.emph;
  assign EQUALIZER_ENABLE_OUT = ctl_reg.eq;
  assign EQ_ROUTE_OUT         = ctl_reg.eq_route;
  assign EQ_BYPASS_OUT        = ctl_reg.bypass_route;
  assign CASCADE_DATA_OUT     = lnk.last_stage;
  // buffered copy of the serial clock, no retiming so the next device
  // sees data and clock with their original relation
  assign CASCADE_CLOCK_OUT    = SERIAL_CLOCK_IN;

  sequence s_strobe_rise;
    ctl_reg.strobe_sync && !ctl_reg.strobe_prev;
  endsequence

  sequence s_load_then_hold;
    s_strobe_rise ##1 ctl_reg.strobe_sync [*3];
  endsequence

  sequence s_settings_default;
    EMPHASIS_LEVEL_OUT == secp_pkg::EMPH_0DB && EQUALIZER_ENABLE_OUT == secp_pkg::EQ_OFF
      && !EQ_ROUTE_OUT && EQ_BYPASS_OUT;
  endsequence

  sequence s_held_high;
    (ctl_reg.strobe_sync && ctl_reg.strobe_prev) [*8];
  endsequence

  a_fallback_low: assert property (
    @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    !ctl_reg.strobe_sync |=> EMPHASIS_LEVEL_OUT == secp_pkg::EMPH_0DB && !EQUALIZER_ENABLE_OUT
  ) else $error("settings not at fallback while strobe low");

  a_capture_emph: assert property (
    @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    s_strobe_rise |=>
      EMPHASIS_LEVEL_OUT == $past(ctl_reg.word_sync[secp_pkg::EMPH_MSB:secp_pkg::EMPH_LSB])
  ) else $error("emphasis not captured on strobe rise");

  a_capture_eq_lsb: assert property (
    @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    s_strobe_rise |=> EQUALIZER_ENABLE_OUT == $past(ctl_reg.word_sync[secp_pkg::EQ_BIT])
  ) else $error("equalizer enable not taken from word lsb");

  a_hold_while_high: assert property (
    @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    s_load_then_hold |=>
      EMPHASIS_LEVEL_OUT == $past(ctl_reg.word_sync[secp_pkg::EMPH_MSB:secp_pkg::EMPH_LSB], 4)
      && EQUALIZER_ENABLE_OUT == $past(ctl_reg.word_sync[secp_pkg::EQ_BIT], 4)
  ) else $error("settings drifted while strobe held high");

  a_no_change_mid_high: assert property (
    @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    ctl_reg.strobe_sync && ctl_reg.strobe_prev |=>
      $stable(EMPHASIS_LEVEL_OUT) && $stable(EQUALIZER_ENABLE_OUT)
  ) else $error("settings changed without a strobe edge");

  // pin checks: two sync stages and the capture stage lie between pin and outputs
  a_strobe_latency: assert property (
    @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    $rose(CONFIG_LOAD_STROBE_IN) |=> ##2
      EMPHASIS_LEVEL_OUT == $past(lnk.word[secp_pkg::EMPH_MSB:secp_pkg::EMPH_LSB], 3)
  ) else $error("emphasis not taken from the word three clocks after strobe rise");

  a_route_onehot: assert property (
    @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    (EQ_ROUTE_OUT != EQ_BYPASS_OUT) && (EQ_ROUTE_OUT == EQUALIZER_ENABLE_OUT)
  ) else $error("line path switch does not follow equalizer enable");

  a_reset_defaults: assert property (
    @(posedge REF_CLK_IN) disable iff (1'b0)
    SYS_RST_IN |=> EMPHASIS_LEVEL_OUT == secp_pkg::EMPH_0DB && !EQUALIZER_ENABLE_OUT
      && ctl_reg.link_rst && EQ_BYPASS_OUT
  ) else $error("reset did not apply 0 dB with equalizer off");

  a_fallback_route: assert property (
    @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    !ctl_reg.strobe_sync |=> !EQ_ROUTE_OUT && EQ_BYPASS_OUT
  ) else $error("line path not bypassed while strobe low");

  a_fallback_latency: assert property (
    @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    $fell(CONFIG_LOAD_STROBE_IN) |=> ##2 s_settings_default
  ) else $error("settings not at fallback three clocks after strobe fall");

  a_low_no_load: assert property (
    @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    !CONFIG_LOAD_STROBE_IN [*3] |=> s_settings_default
  ) else $error("settings left fallback while strobe pin low");

  a_eq_capture_pin: assert property (
    @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    $rose(CONFIG_LOAD_STROBE_IN) |=> ##2 EQUALIZER_ENABLE_OUT == $past(lnk.word[secp_pkg::EQ_BIT], 3)
  ) else $error("equalizer enable not taken from the word after strobe rise");

  a_capture_route: assert property (
    @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    s_strobe_rise |=> EQ_ROUTE_OUT == $past(ctl_reg.word_sync[secp_pkg::EQ_BIT])
      && EQ_BYPASS_OUT == !EQ_ROUTE_OUT
  ) else $error("line path not set from captured equalizer enable");

  // shifting while the strobe stays high must not leak into the settings
  a_emph_frozen_high: assert property (
    @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    ctl_reg.strobe_prev |=>
      EMPHASIS_LEVEL_OUT == secp_pkg::EMPH_0DB || $stable(EMPHASIS_LEVEL_OUT)
  ) else $error("emphasis changed without a strobe rise");

  a_eq_frozen_high: assert property (
    @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    ctl_reg.strobe_prev |=>
      EQUALIZER_ENABLE_OUT == secp_pkg::EQ_OFF || $stable(EQUALIZER_ENABLE_OUT)
  ) else $error("equalizer enable changed without a strobe rise");

  a_hold_long: assert property (
    @(posedge REF_CLK_IN) disable iff (SYS_RST_IN)
    s_held_high |=> EMPHASIS_LEVEL_OUT == $past(EMPHASIS_LEVEL_OUT, 8)
      && EQUALIZER_ENABLE_OUT == $past(EQUALIZER_ENABLE_OUT, 8)
  ) else $error("settings not kept over a long high strobe");

  a_release_idle: assert property (
    @(posedge REF_CLK_IN) disable iff (1'b0)
    $fell(SYS_RST_IN) |-> s_settings_default ##1 s_settings_default
  ) else $error("settings left defaults just after reset release");

  a_link_rst_release: assert property (
    @(posedge REF_CLK_IN) disable iff (1'b0)
    $fell(SYS_RST_IN) |-> ctl_reg.link_rst ##1 !ctl_reg.link_rst
  ) else $error("link reset did not drop one clock after release");

  a_link_clear: assert property (
    @(posedge REF_CLK_IN) disable iff (1'b0)
    ctl_reg.link_rst |-> lnk.word == secp_pkg::WORD_RST && !CASCADE_DATA_OUT
  ) else $error("shift register not cleared under link reset");

  // checked on the link clock, the domain that launches the cascade data
  a_cascade_follow: assert property (
    @(posedge SERIAL_CLOCK_IN) disable iff (ctl_reg.link_rst)
    ##1 CASCADE_DATA_OUT == $past(lnk.word[secp_pkg::LAST_BIT-1])
  ) else $error("cascade data is not the stage below one clock back");

endmodule

// ---- hw/secp_pkg.sv ----
// constants and state types of the serial emphasis configuration port
package secp_pkg;

  // configuration word layout: emphasis code on top, equalizer enable in the lsb
  localparam int unsigned WORD_W   = 5;
  localparam int unsigned EMPH_W   = 4;
  localparam int unsigned EMPH_MSB = 4;
  localparam int unsigned EMPH_LSB = 1;
  localparam int unsigned EQ_BIT   = 0;
  localparam int unsigned LAST_BIT = WORD_W - 1;

  // settings applied after reset and while the load strobe is low
  localparam logic [EMPH_W-1:0] EMPH_0DB  = 4'h0;
  localparam logic              EQ_OFF    = 1'h0;
  localparam logic [WORD_W-1:0] WORD_RST  = 5'h00;

  // serial clock limit, kept for the bench and for the latency figures
  localparam int unsigned SCLK_MAX_MHZ = 20;
  localparam int unsigned REF_CLK_MHZ  = 25;

  // strobe and word each pass two synchroniser stages, then one capture stage
  localparam int unsigned SYNC_STAGES   = 2;
  localparam int unsigned APPLY_LATENCY = SYNC_STAGES + 1;

  typedef struct packed {
    logic [WORD_W-1:0] word;
  } secp_shift_state_t;

  typedef struct packed {
    logic              link_rst;
    logic              strobe_meta;
    logic              strobe_sync;
    logic              strobe_prev;
    logic [WORD_W-1:0] word_meta;
    logic [WORD_W-1:0] word_sync;
    logic [EMPH_W-1:0] emph;
    logic              eq;
    logic              eq_route;
    logic              bypass_route;
  } secp_ctl_state_t;

  localparam secp_shift_state_t SHIFT_RST = '{word: WORD_RST};

  localparam secp_ctl_state_t CTL_RST = '{
    link_rst:     1'h1,
    strobe_meta:  1'h0,
    strobe_sync:  1'h0,
    strobe_prev:  1'h0,
    word_meta:    WORD_RST,
    word_sync:    WORD_RST,
    emph:         EMPH_0DB,
    eq:           EQ_OFF,
    eq_route:     1'h0,
    bypass_route: 1'h1
  };

endpackage

// ---- hw/secp_link_if.sv ----
// shift register contents handed from the serial clock domain to the control logic
`timescale 1ns/100ps
interface secp_link_if;
  logic [secp_pkg::WORD_W-1:0] word;
  logic                        last_stage;

  modport shifter (output word, output last_stage);
  modport sink    (input  word, input  last_stage);
endinterface

// ---- hw/secp_shift.sv ----
// five-bit configuration shift register on the serial clock
`timescale 1ns/100ps
module secp_shift (
  // link clock and reset
  input  wire logic       serial_clock_in,
  input  wire logic       link_rst_in,
  // serial data
  input  wire logic       serial_data_in,
  // contents toward the control logic
  secp_link_if.shifter    lnk
);

  secp_pkg::secp_shift_state_t shift_reg;
  secp_pkg::secp_shift_state_t shift_next;

  always_comb begin
    shift_next = shift_reg;
    // new bit enters stage 0; the first bit sent ends in the msb
    shift_next.word = {shift_reg.word[secp_pkg::LAST_BIT-1:0], serial_data_in};
  end

  // reset comes from a control-domain flop, so it is a constant-only async clear
  always_ff @(posedge serial_clock_in or posedge link_rst_in) begin
    if (link_rst_in) begin
      shift_reg <= secp_pkg::SHIFT_RST;
    end else begin
      shift_reg <= shift_next;
    end
  end

  assign lnk.word       = shift_reg.word;
  assign lnk.last_stage = shift_reg.word[secp_pkg::LAST_BIT];

  a_shift_advance: assert property (
    @(posedge serial_clock_in) disable iff (link_rst_in)
    ##1 lnk.word[secp_pkg::LAST_BIT:1] == $past(lnk.word[secp_pkg::LAST_BIT-1:0])
  ) else $error("shift register did not advance by one stage");

  a_cascade_delay: assert property (
    @(posedge serial_clock_in) disable iff (link_rst_in)
    1'b1 ##5 1'b1 |-> lnk.last_stage == $past(serial_data_in, 5)
  ) else $error("cascade data is not the input five clocks back");

endmodule

// ---- verif/secp_ctl_model.sv ----
// behavioural controller driving the serial configuration link
`timescale 1ns/100ps
module secp_ctl_model (
  // reference clock for strobe timing
  input  wire logic ref_clk_in,
  // link toward the port
  output logic      sclk_out,
  output logic      sdata_out,
  output logic      strobe_out,
  // cascade seen back
  input  wire logic casc_data_in,
  input  wire logic casc_clk_in
);
  logic clk_ok;
  initial begin
    sclk_out   = 1'b0;
    sdata_out  = 1'b0;
    strobe_out = 1'b0;
    clk_ok     = 1'b1;
  end
  // link clock stands low between frames, 125 ns period within them
  task automatic send_word(input logic [4:0] w, output logic [4:0] casc);
    for (int i = 4; i >= 0; i--) begin
      sdata_out = w[i];
      // cascade data taken as the next device takes it, just before the rise
      #62.5 casc[i] = casc_data_in;
      if (casc_clk_in !== 1'b0) clk_ok = 1'b0;
      sclk_out = 1'b1;
      #1 if (casc_clk_in !== 1'b1) clk_ok = 1'b0;
      #61.5 sclk_out = 1'b0;
    end
    // released data line shows no stale value
    #1 sdata_out = ~sdata_out;
    #100;
  endtask
  task automatic set_strobe(input logic v);
    @(negedge ref_clk_in) strobe_out <= v;
    repeat (4) @(negedge ref_clk_in);
  endtask
endmodule

// ---- verif/serial_emphasis_config_port_tb.sv ----
// self-checking bench of the serial emphasis configuration port
`timescale 1ns/100ps
module serial_emphasis_config_port_tb;
  logic       ref_clk;
  logic       sys_rst;
  logic       sclk, sdata, strobe, casc_d, casc_c, eq_en, eq_rt, eq_bp;
  logic [3:0] emph;
  logic [4:0] casc;
  int         errors;
  int         n_tests;
  int         cycles;
  secp_ctl_model pm_u (.ref_clk_in(ref_clk), .sclk_out(sclk), .sdata_out(sdata),
    .strobe_out(strobe), .casc_data_in(casc_d), .casc_clk_in(casc_c));
  secp_top dut_u (.REF_CLK_IN(ref_clk), .SYS_RST_IN(sys_rst), .SERIAL_CLOCK_IN(sclk),
    .SERIAL_DATA_IN(sdata), .CONFIG_LOAD_STROBE_IN(strobe), .CASCADE_DATA_OUT(casc_d),
    .CASCADE_CLOCK_OUT(casc_c), .EMPHASIS_LEVEL_OUT(emph), .EQUALIZER_ENABLE_OUT(eq_en),
    .EQ_ROUTE_OUT(eq_rt), .EQ_BYPASS_OUT(eq_bp));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("[ERR] %0t run did not finish", $time);
      end_sim();
    end
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // expected outputs: fallback when not loaded, else word fields
  task automatic check(input logic ld, input logic [4:0] w);
    logic [6:0] exp;
    exp = ld ? {w[4:1], w[0], w[0], ~w[0]} : 7'h01;
    n_tests++;
    if ({emph, eq_en, eq_rt, eq_bp} !== exp) begin
      errors++;
      $display("[ERR] %0t settings %h expected %h", $time, {emph, eq_en, eq_rt, eq_bp}, exp);
    end
  endtask
  task automatic t_reset();
    repeat (3) @(negedge ref_clk);
    check(1'b0, 5'h00);
    $display("reset test done");
  endtask
  task automatic t_load();
    logic [4:0] w [4] = '{5'h1F, 5'h10, 5'h01, 5'h0A};
    foreach (w[i]) begin
      pm_u.set_strobe(1'b0);
      check(1'b0, w[i]);
      pm_u.send_word(w[i], casc);
      check(1'b0, w[i]);
      pm_u.set_strobe(1'b1);
      check(1'b1, w[i]);
    end
    $display("load test done");
  endtask
  task automatic t_hold();
    pm_u.set_strobe(1'b0);
    pm_u.send_word(5'h15, casc);
    pm_u.set_strobe(1'b1);
    pm_u.send_word(5'h0B, casc);
    repeat (4) @(negedge ref_clk);
    check(1'b1, 5'h15);
    pm_u.set_strobe(1'b0);
    check(1'b0, 5'h15);
    $display("hold test done");
  endtask
  task automatic t_cascade();
    pm_u.send_word(5'h13, casc);
    n_tests++;
    if (casc !== 5'h0B) begin
      errors++;
      $display("[ERR] %0t cascade showed %h before the chain word", $time, casc);
    end
    pm_u.send_word(5'h0C, casc);
    n_tests++;
    if (casc !== 5'h13 || pm_u.clk_ok !== 1'b1) begin
      errors++;
      $display("[ERR] %0t cascade showed %h", $time, casc);
    end
    $display("cascade test done");
  endtask
  initial begin
    sys_rst = 1'b1;
    repeat (6) @(negedge ref_clk);
    sys_rst = 1'b0;
    t_reset();
    t_load();
    t_hold();
    t_cascade();
    end_sim();
  end
endmodule
